// file: core/missing_clock_detect.v
`timescale 1ns/100ps
`default_nettype none
`include "rtc_osc_map.vh"
module missing_clock_detect
#(
    parameter LIMIT = `MISSING_CLOCK_CYC
)
(
    input  wire clk,
    input  wire arst_n,
    input  wire enable,
    input  wire level,
    output reg  timeout
);
    reg        lastLevel_reg;  // previous sample
    reg [15:0] stuckCount_reg; // cycles without an edge
    reg        armed_reg;      // one-shot guard

    // counts cycles the timebase stays at one level
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lastLevel_reg  <= 1'b0;
            stuckCount_reg <= 16'h0000;
            armed_reg      <= 1'b1;
            timeout        <= 1'b0;
        end
        else
        begin
            lastLevel_reg <= level;
            timeout       <= 1'b0;
            if (!enable || level != lastLevel_reg)
            begin
                // edge seen or disabled: restart and rearm
                stuckCount_reg <= 16'h0000;
                armed_reg      <= 1'b1;
            end
            else if (stuckCount_reg >= LIMIT[15:0])
            begin
                // one pulse per stall
                timeout   <= armed_reg;
                armed_reg <= 1'b0;
            end
            else
            begin
                stuckCount_reg <= stuckCount_reg + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// file: core/rtc_osc_map.vh
`ifndef RTC_OSC_MAP_VH
`define RTC_OSC_MAP_VH
// indirect register indices
`define IDX_RTC_CONTROL     4'h4
`define IDX_OSC_CONTROL     4'h5
`define IDX_WIDTH           4
// control register fields
`define CTL_POWER_BIT       7
`define CTL_MCD_EN_BIT      6
`define CTL_FAIL_BIT        5
// oscillator control fields
`define OSC_AGC_BIT         7
`define OSC_MODE_BIT        6
`define OSC_BIAS_BIT        5
`define OSC_VALID_BIT       4
// reset values
`define CTL_RESET           8'h00
`define OSC_RESET           8'h00
// timing
`define CLK_HZ              20000000
`define MISSING_CLOCK_NS    50000
`define MISSING_CLOCK_CYC   ((`MISSING_CLOCK_NS * (`CLK_HZ / 1000000)) / 1000)
`define VALID_EDGES         16'h0400
`endif

// file: core/rtc_oscillator_control.v
// Overview of operation
// - block timebase comes from own oscillator
// - crystal 32.768 kHz, self-oscillate 20/40 kHz
// - mode bit 1 crystal, 0 self-oscillate
// - self-oscillate bias bit picks 20/40 kHz
// - self-oscillate mode valid without waiting
// - gain control bit 7 trims crystal amplitude
// - bias doubling bit 5 doubles bias current
// - stuck timebase over 50 us sets fail
// - timeout wakes oscillator, interrupt, reset
// - power bit 7 enables oscillator and bias
// - timebase selectable as clock, routable to pin
// - control registers reached via address/data ports
`timescale 1ns/100ps
`default_nettype none
`include "rtc_osc_map.vh"
module rtc_oscillator_control
#(
    parameter MISSING_LIMIT = `MISSING_CLOCK_CYC,
    parameter VALID_COUNT   = `VALID_EDGES
)
(
    input  wire       clk,
    input  wire       arst_n,
    input  wire       addrWrite,
    input  wire [7:0] addrData,
    output wire [7:0] addrRead,
    input  wire       dataWrite,
    input  wire       dataReadStrobe,
    input  wire [7:0] dataIn,
    output reg  [7:0] dataOut,
    input  wire       rtcTimebaseClock,
    input  wire       rtcIntEnable,
    input  wire       rtcResetEnable,
    output reg        oscPowerEnable,
    output reg        autoGainEnable,
    output reg        biasDoubleEnable,
    output reg        oscModeSelect,
    output reg        wakeInternalOsc,
    output reg        rtcInterrupt,
    output reg        mcuReset,
    input  wire       sysClockSelect,
    input  wire       pinRouteEnable,
    output wire       systemClockSource,
    output wire       timebasePinOut
);
    // register state of the block; software reaches it only through
    // the index port and the data port, so reaching a new register takes two steps:
    // load the index, then strobe a write or a read on the data port
    // the index stays put between accesses
    reg  [`IDX_WIDTH-1:0] indexReg;       // indirect address port
    reg                   failFlag_reg;   // sticky oscillator fail
    reg                   mcdEnable_reg;  // detector enable
    reg                   oscValid_reg;   // clock valid status
    reg  [15:0]           edgeCount_reg;  // crystal start-up counter
    reg                   prevTb_reg;     // last synced timebase
    wire                  tbSync;         // synchronised timebase
    wire                  timeoutPulse;   // detector one-shot
    wire                  ctlSel;         // control reg addressed
    wire                  oscSel;         // osc control addressed
    wire                  tbEdge;         // timebase toggled
    wire                  settled;        // crystal saw enough edges
    wire                  ctlWrite;       // data write to control reg
    wire                  oscWrite;       // data write to osc control
    reg                   failFlag_next;  // next fail flag value
    reg  [1:0]            startState_reg;  // start-up sequencer state
    reg  [1:0]            startState_next; // sequencer next state
    reg  [15:0]           edgeCount_next; // next settle count
    reg  [7:0]            readMux;        // value a read would return

    // start-up sequencer states
    localparam [1:0] ST_OFF    = 2'b00; // oscillator unpowered
    localparam [1:0] ST_SETTLE = 2'b01; // crystal still settling
    localparam [1:0] ST_RUN    = 2'b10; // clock reported valid

    // index readback and register decode
    assign addrRead = {{(8-`IDX_WIDTH){1'b0}}, indexReg};
    assign ctlSel   = (indexReg == `IDX_RTC_CONTROL);
    assign oscSel   = (indexReg == `IDX_OSC_CONTROL);
    assign tbEdge   = (tbSync != prevTb_reg);
    assign settled  = (edgeCount_reg >= VALID_COUNT[15:0]);
    assign ctlWrite = dataWrite && ctlSel;
    assign oscWrite = dataWrite && oscSel;

    // timebase is an outside clock: sample it first
    // two flops keep metastability away from the edge logic
    timebase_sync u_sync
    (
        .clk     (clk),
        .arst_n  (arst_n),
        .asyncIn (rtcTimebaseClock),
        .syncOut (tbSync)
    );

    // stuck-level watchdog on the timebase
    // its count starts at the synchronised edge, after the two synchroniser cycles
    // it runs only while software enables it
    missing_clock_detect #(.LIMIT(MISSING_LIMIT)) u_mcd
    (
        .clk     (clk),
        .arst_n  (arst_n),
        .enable  (mcdEnable_reg),
        .level   (tbSync),
        .timeout (timeoutPulse)
    );

    // block runs off its own oscillator timebase
    // the synchronised copy is gated, so no logic here reads the raw pin;
    // the routed clock lags the oscillator by two system clocks
    // and is held low while its select is off
    assign systemClockSource = sysClockSelect ? tbSync : 1'b0;
    assign timebasePinOut    = pinRouteEnable ? tbSync : 1'b0;

    // indirect address port
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            // index cleared on reset
            indexReg <= {`IDX_WIDTH{1'b0}};
        else if (addrWrite)
            // upper address bits are ignored
            // no auto-increment for these two registers
            indexReg <= addrData[`IDX_WIDTH-1:0];
    end

    // register writes through the data port
    // writes to any other index are ignored
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // oscillator off, detector off
            oscPowerEnable   <= 1'b0;
            mcdEnable_reg    <= 1'b0;
            autoGainEnable   <= 1'b0;
            oscModeSelect    <= 1'b0;
            biasDoubleEnable <= 1'b0;
        end
        else if (ctlWrite)
        begin
            // control register: power and detector enable
            oscPowerEnable <= dataIn[`CTL_POWER_BIT];
            mcdEnable_reg  <= dataIn[`CTL_MCD_EN_BIT];
        end
        else if (oscWrite)
        begin
            // oscillator control: valid bit is read-only
            autoGainEnable   <= dataIn[`OSC_AGC_BIT];
            oscModeSelect    <= dataIn[`OSC_MODE_BIT];
            biasDoubleEnable <= dataIn[`OSC_BIAS_BIT];
        end
    end

    // fail flag next value: hardware set wins over software clear
    always @*
    begin
        failFlag_next = failFlag_reg;
        if (timeoutPulse)
            // detector one-shot fired
            failFlag_next = 1'b1;
        else if (ctlWrite && !dataIn[`CTL_FAIL_BIT])
            // software clears by writing zero; a one leaves it
            failFlag_next = 1'b0;
    end

    // fail flag register
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            failFlag_reg <= 1'b0;
        else
            failFlag_reg <= failFlag_next;
    end

    // crystal start-up: valid only after the timebase has toggled
    // VALID_COUNT times; self-oscillate is valid at once
    // sequencer next state and settle count
    always @*
    begin
        startState_next = startState_reg;
        edgeCount_next  = edgeCount_reg;
        case (startState_reg)
            ST_OFF:
            begin
                // powered down: forget any earlier settling
                edgeCount_next = 16'h0000;
                if (oscPowerEnable && !oscModeSelect)
                    startState_next = ST_RUN;
                else if (oscPowerEnable)
                    startState_next = ST_SETTLE;
            end
            ST_SETTLE:
            begin
                // count synchronised timebase edges while the crystal settles
                if (!oscPowerEnable)
                    startState_next = ST_OFF;
                else if (!oscModeSelect)
                    startState_next = ST_RUN;
                else if (settled)
                    startState_next = ST_RUN;
                else if (tbEdge)
                    edgeCount_next = edgeCount_reg + 16'h0001;
            end
            ST_RUN:
            begin
                // power loss, or crystal chosen before it settled, restarts
                if (!oscPowerEnable)
                    startState_next = ST_OFF;
                else if (oscModeSelect && !settled)
                    startState_next = ST_SETTLE;
            end
            default:
            begin
                // unused code: fall back to unpowered
                startState_next = ST_OFF;
                edgeCount_next  = 16'h0000;
            end
        endcase
    end

    // sequencer and status flops; valid follows the next state
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prevTb_reg     <= 1'b0;
            edgeCount_reg  <= 16'h0000;
            startState_reg <= ST_OFF;
            oscValid_reg   <= 1'b0;
        end
        else
        begin
            prevTb_reg     <= tbSync;
            edgeCount_reg  <= edgeCount_next;
            startState_reg <= startState_next;
            oscValid_reg   <= (startState_next == ST_RUN);
        end
    end

    // timeout consequences, one-cycle pulses
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            // no consequence pending
            wakeInternalOsc <= 1'b0;
            rtcInterrupt    <= 1'b0;
            mcuReset        <= 1'b0;
        end
        else
        begin
            // each consequence lasts one cycle after the timeout
            // wake is unconditional; interrupt and reset follow their gates
            wakeInternalOsc <= timeoutPulse;
            rtcInterrupt    <= timeoutPulse && rtcIntEnable;
            mcuReset        <= timeoutPulse && rtcResetEnable;
        end
    end

    // read multiplexer over the indirect registers
    // fields sit at their mapped bit positions, other bits read zero
    always @*
    begin
        readMux = 8'h00;
        case (indexReg)
            `IDX_RTC_CONTROL:
            begin
                // timer and alarm bits are not kept here
                readMux[`CTL_POWER_BIT]  = oscPowerEnable;
                readMux[`CTL_MCD_EN_BIT] = mcdEnable_reg;
                readMux[`CTL_FAIL_BIT]   = failFlag_reg;
            end
            `IDX_OSC_CONTROL:
            begin
                // valid is status only
                readMux[`OSC_AGC_BIT]   = autoGainEnable;
                readMux[`OSC_MODE_BIT]  = oscModeSelect;
                readMux[`OSC_BIAS_BIT]  = biasDoubleEnable;
                readMux[`OSC_VALID_BIT] = oscValid_reg;
            end
            default:
            begin
                // unmapped index reads as zero
                readMux = 8'h00;
            end
        endcase
    end

    // data port read value, registered
    // holds until the next strobe
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            dataOut <= 8'h00;
        else if (dataReadStrobe)
            // value of the indexed register at the strobe
            dataOut <= readMux;
    end
endmodule
`default_nettype wire

// file: core/timebase_sync.v
`timescale 1ns/100ps
`default_nettype none
module timebase_sync
(
    input  wire clk,
    input  wire arst_n,
    input  wire asyncIn,
    output wire syncOut
);
    reg firstReg;   // only read by secondReg
    reg secondReg;  // stable sample

    // two-flop synchroniser
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            firstReg  <= 1'b0;
            secondReg <= 1'b0;
        end
        else
        begin
            firstReg  <= asyncIn;
            secondReg <= firstReg;
        end
    end

    assign syncOut = secondReg;
endmodule
`default_nettype wire

// file: dv/rtc_osc_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module rtc_osc_monitor
(
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [7:0] addrRead,
    input wire logic       dataWrite,
    input wire logic [7:0] dataIn,
    input wire logic       oscPowerEnable,
    input wire logic       autoGainEnable,
    input wire logic       biasDoubleEnable,
    input wire logic       oscModeSelect,
    input wire logic       wakeInternalOsc,
    input wire logic       rtcInterrupt,
    input wire logic       mcuReset,
    input wire logic       sysClockSelect,
    input wire logic       systemClockSource
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // writes aimed at the control and oscillator indices
    wire ctlWr = dataWrite && addrRead[3:0] == 4'h4;
    wire oscWr = dataWrite && addrRead[3:0] == 4'h5;
    a_power_write: assert property (ctlWr |=> oscPowerEnable == $past(dataIn[7]))
        else $error("power bit mismatch");
    a_mode_write: assert property (oscWr |=> oscModeSelect == $past(dataIn[6]))
        else $error("mode bit mismatch");
    a_gain_write: assert property (oscWr |=> autoGainEnable == $past(dataIn[7]))
        else $error("gain bit mismatch");
    a_bias_write: assert property (oscWr |=> biasDoubleEnable == $past(dataIn[5]))
        else $error("bias bit mismatch");
    a_wake_pulse: assert property (wakeInternalOsc |=> !wakeInternalOsc)
        else $error("wake pulse too long");
    a_irq_with_wake: assert property (rtcInterrupt |-> wakeInternalOsc)
        else $error("interrupt without timeout");
    a_reset_with_wake: assert property (mcuReset |-> wakeInternalOsc)
        else $error("reset without timeout");
    a_system_clock_source_gate: assert property (!sysClockSelect |-> !systemClockSource)
        else $error("clock source not gated");
    c_timeout: cover property (wakeInternalOsc && rtcInterrupt && mcuReset);
    c_osc_write: cover property (oscWr);
    c_quiet_timeout: cover property (wakeInternalOsc && !rtcInterrupt);
endmodule
bind rtc_oscillator_control rtc_osc_monitor mon_u (.clk, .arst_n, .addrRead, .dataWrite,
    .dataIn, .oscPowerEnable, .autoGainEnable, .biasDoubleEnable, .oscModeSelect,
    .wakeInternalOsc, .rtcInterrupt, .mcuReset, .sysClockSelect, .systemClockSource);
`default_nettype wire

// file: dv/test_rtc_oscillator_control.sv
`timescale 1ns/100ps
`default_nettype none
module test_rtc_oscillator_control;
    // stimulus, model state and counters
    logic       clk = 0, arst_n = 0, addrWrite = 0, dataWrite = 0, dataReadStrobe = 0;
    logic       rtcTimebaseClock = 0, rtcIntEnable = 0, rtcResetEnable = 0;
    logic       sysClockSelect = 0, pinRouteEnable = 0;
    logic [7:0] addrData = 0, dataIn = 0, ctlM = 0, oscM = 0, v;
    wire logic [7:0] addrRead, dataOut;
    wire logic  oscPowerEnable, autoGainEnable, biasDoubleEnable, oscModeSelect;
    wire logic  wakeInternalOsc, rtcInterrupt, mcuReset, systemClockSource, timebasePinOut;
    int         err_total = 0, n_tests = 0, cyc = 0, k;
    // short counts keep the run brief
    rtc_oscillator_control #(.MISSING_LIMIT(40), .VALID_COUNT(8)) dut_u (.clk, .arst_n,
        .addrWrite, .addrData, .addrRead, .dataWrite, .dataReadStrobe, .dataIn, .dataOut,
        .rtcTimebaseClock, .rtcIntEnable, .rtcResetEnable, .oscPowerEnable, .autoGainEnable,
        .biasDoubleEnable, .oscModeSelect, .wakeInternalOsc, .rtcInterrupt, .mcuReset,
        .sysClockSelect, .pinRouteEnable, .systemClockSource, .timebasePinOut);
    initial forever #25 clk = ~clk;
    // hang guard
    always @(posedge clk)
        if (++cyc > 20000) begin
            err_total++;
            $display("BAD %0t timeout", $time);
            final_report();
        end
    task automatic tick(); @(posedge clk); #1; endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin err_total++; $display("BAD %0t got %h exp %h", $time, got, exp); end
    endtask
    // index then data cycle; model follows writable bits
    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        addrWrite = 1; addrData = {4'h0, i}; dataIn = d; tick();
        addrWrite = 0; dataWrite = 1; tick(); dataWrite = 0;
        if (i == 4'h4) ctlM = (d & 8'hC0) | (ctlM & d & 8'h20);
        if (i == 4'h5) oscM = (d & 8'hE0) | (oscM & 8'h10);
    endtask
    task automatic rd(input logic [3:0] i);
        addrWrite = 1; addrData = {4'h0, i}; tick();
        addrWrite = 0; dataReadStrobe = 1; tick(); dataReadStrobe = 0;
        chk(addrRead, {4'h0, i});
        chk(dataOut, i == 4'h4 ? ctlM : i == 4'h5 ? oscM : 8'h00);
    endtask
    task automatic outs();
        chk({oscPowerEnable, autoGainEnable, biasDoubleEnable, oscModeSelect, 4'h0},
            {ctlM[7], oscM[7], oscM[5], oscM[6], 4'h0});
    endtask
    task automatic final_report();
        $display("tests %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        v = $urandom(32'hef45);
        repeat (3) @(posedge clk);
        #1 arst_n = 1;
        rd(4'h4); rd(4'h5); rd(4'h3);
        wr(4'h3, 8'hFF); rd(4'h3);
        wr(4'h5, 8'hE0); wr(4'h4, 8'h80); outs();
        rd(4'h5);
        repeat (20) begin rtcTimebaseClock = ~rtcTimebaseClock; repeat (3) tick(); end
        oscM = 8'hF0; rd(4'h5);
        wr(4'h5, 8'hC0); rd(4'h5);
        wr(4'h4, 8'h00); wr(4'h5, 8'h20); oscM = 8'h20; rd(4'h5); outs();
        wr(4'h4, 8'h80); tick(); tick(); oscM = 8'h30; rd(4'h5);
        for (int j = 0; j < 2; j++) begin
            rtcIntEnable = !j; rtcResetEnable = !j; wr(4'h4, 8'hC0);
            k = 0;
            while (!wakeInternalOsc && k < 200) begin tick(); k++; end
            chk({wakeInternalOsc, rtcInterrupt, mcuReset}, {1'b1, !j[0], !j[0]});
            ctlM = 8'hE0; rd(4'h4); wr(4'h4, 8'h00); rd(4'h4);
        end
        repeat (20) begin
            v = $urandom; v[7] = v[7] & v[6]; wr(4'h5, v);
            v = $urandom; wr(4'h4, v & 8'hBF); outs();
            {sysClockSelect, pinRouteEnable} = 2'($urandom);
            rtcTimebaseClock = 1'($urandom); repeat (3) tick();
            chk({systemClockSource, timebasePinOut},
                {sysClockSelect & rtcTimebaseClock, pinRouteEnable & rtcTimebaseClock});
        end
        final_report();
    end
endmodule
`default_nettype wire
